// *** hw/cbpc_top.sv ***
// Clock, buzzer and power control: dividers, tone gating, oscillator
// output, low-battery strobing and power-saving control registers.
// Assumes clk_i stands in for the crystal and the host drives the
// register port from logic on the same clock.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Timebase, sample clock and tone are all divided from the crystal clock.
// - Timebase is 1 MHz or 125 kHz by select; low when oscillator off.
// - Sample clock is 166.67 or 83.33 kHz by select; low when off.
// - Tone runs at 2.6 kHz when forced, or continuity and comparator high.
// - Tone pin is open drain; an external pull-up makes its high.
// - Tone force and continuity enable are host-writable; comparator is input.
// - Oscillator output carries 2 MHz unless disabled, then held at 0.
// - Low-battery flag is high when the battery is below 6.8 V.
// - Supply switch enables close the switched-supply PMOS when one.
// - Ground regulator disable bit one turns the ground regulator off.
// - Bit placement in misc, converter setup and converter gain registers.
// - Reset clears every control register to zero.
// - Comparator result also drives a dedicated comparator output.
module cbpc_top
    import cbpc_pkg::*;
#(
    parameter int TONE_HALF = cbpc_pkg::TONE_HALF_CYC,
    parameter int SENSE_WAIT = cbpc_pkg::SENSE_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire cbpc_pkg::cbpc_bus_s bus_i,
    output logic [7:0] rdata_o,
    input wire logic comparator_result_i,
    input wire logic battery_below_i,
    output logic timebase_clock_o,
    output logic adc_sample_clock_o,
    output logic osc_out_pin_o,
    output logic tone_pin_o,
    output logic tone_pin_oe_o,
    output logic comparator_o,
    output logic osc_disable_n_o,
    output logic osc_out_disable_o,
    output cbpc_pkg::cbpc_ana_s ana_o
);

    import cbpc_pkg::*;

    // ***************************************************************
    // Elaboration checks
    // ***************************************************************
    if (TONE_HALF < 1) begin : g_chk_tone
        $error("cbpc_top: TONE_HALF must be one or more");
    end
    if (SENSE_WAIT < 1) begin : g_chk_sense
        $error("cbpc_top: SENSE_WAIT must be one or more");
    end

    localparam int SW = $clog2(SENSE_WAIT + 1);

    // ***************************************************************
    // Control registers
    // ***************************************************************
    logic [7:0] clk_ctrl_r;
    logic [3:0] mode_r;
    logic [1:0] ohm_r;
    logic cmp_en_r;
    logic rct_en_r;
    logic acbuf_en_r;
    logic conv_en_r;
    logic ana_sw_r;
    logic dig_sw_r;
    logic osc_out_dis_r;
    logic xtal_dis_r;
    logic gnd_dis_r;

    // Clock and tone control bits, host writable
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            clk_ctrl_r <= REG_RESET;
        end else if (bus_i.we && bus_i.addr == REG_CLK_CTRL) begin
            clk_ctrl_r <= {3'h0, bus_i.wdata[4:0]};
        end
    end

    // Function mode and ohm source
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_r <= REG_RESET[3:0];
            ohm_r <= OHM_OFF;
        end else if (bus_i.we && bus_i.addr == REG_FUNC) begin
            mode_r <= bus_i.wdata[3:0];
            ohm_r <= bus_i.wdata[B_OHM_LO+1:B_OHM_LO];
        end
    end

    // Analog enables: comparator, rectifier, AC buffer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cmp_en_r <= 1'b0;
            rct_en_r <= 1'b0;
            acbuf_en_r <= 1'b0;
        end else if (bus_i.we && bus_i.addr == REG_ANA_EN) begin
            cmp_en_r <= bus_i.wdata[B_CMP_EN];
            rct_en_r <= bus_i.wdata[B_RCT_EN];
            acbuf_en_r <= bus_i.wdata[B_ACBUF_EN];
        end
    end

    // Converter enable and supply switches
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            conv_en_r <= 1'b0;
            ana_sw_r <= 1'b0;
            dig_sw_r <= 1'b0;
        end else begin
            if (bus_i.we && bus_i.addr == REG_CONV_GAIN) begin
                conv_en_r <= bus_i.wdata[B_CONV_EN];
            end
            if (bus_i.we && bus_i.addr == REG_CONV_SETUP) begin
                ana_sw_r <= bus_i.wdata[B_ANA_SW];
                dig_sw_r <= bus_i.wdata[B_DIG_SW];
            end
        end
    end

    // Oscillator and ground regulator disables
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            osc_out_dis_r <= 1'b0;
            xtal_dis_r <= 1'b0;
            gnd_dis_r <= 1'b0;
        end else begin
            if (bus_i.we && bus_i.addr == REG_MISC_ONE) begin
                osc_out_dis_r <= bus_i.wdata[B_OSC_OUT_DIS];
                xtal_dis_r <= bus_i.wdata[B_XTAL_DIS];
            end
            if (bus_i.we && bus_i.addr == REG_MISC_TWO) begin
                gnd_dis_r <= bus_i.wdata[B_GND_DIS];
            end
        end
    end

    // ***************************************************************
    // Input synchronisers
    // ***************************************************************
    logic cmp_meta_r;
    logic cmp_sync_r;
    logic bat_meta_r;
    logic bat_sync_r;

    // Both inputs come from analog comparators, so two flops each
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
            bat_meta_r <= 1'b0;
            bat_sync_r <= 1'b0;
        end else begin
            cmp_meta_r <= comparator_result_i;
            cmp_sync_r <= cmp_meta_r;
            bat_meta_r <= battery_below_i;
            bat_sync_r <= bat_meta_r;
        end
    end

    // ***************************************************************
    // Clock dividers
    // ***************************************************************
    logic osc_run;
    logic tone_run;
    logic tone_lvl;

    // Timebase, sample clock and oscillator output stop with the crystal disable bit
    assign osc_run = !xtal_dis_r;
    // Tone gating follows the comparator after synchronisation
    assign tone_run = clk_ctrl_r[B_TONE_FORCE]
                      || (clk_ctrl_r[B_CONT_TONE] && cmp_sync_r);

    // Timebase: 1 MHz, or 125 kHz with the select set
    cbpc_divider #(
        .HI_A(TB_FAST_PER / 2), .LO_A(TB_FAST_PER - TB_FAST_PER / 2),
        .HI_B(TB_SLOW_PER / 2), .LO_B(TB_SLOW_PER - TB_SLOW_PER / 2)
    ) u_timebase (
        .clk_i(clk_i), .reset_i(reset_i), .run_i(osc_run),
        .sel_i(clk_ctrl_r[B_TB_SEL]), .clk_o(timebase_clock_o)
    );

    // Sample clock: 166.67 kHz, or 83.33 kHz with the select set
    cbpc_divider #(
        .HI_A(SMP_FAST_PER / 2), .LO_A(SMP_FAST_PER - SMP_FAST_PER / 2),
        .HI_B(SMP_SLOW_PER / 2), .LO_B(SMP_SLOW_PER - SMP_SLOW_PER / 2)
    ) u_sample (
        .clk_i(clk_i), .reset_i(reset_i), .run_i(osc_run),
        .sel_i(clk_ctrl_r[B_SMP_SEL]), .clk_o(adc_sample_clock_o)
    );

    // Oscillator output: 25 cycles, so duty is 12 high to 13 low
    cbpc_divider #(
        .HI_A(OSC_OUT_PER / 2), .LO_A(OSC_OUT_PER - OSC_OUT_PER / 2),
        .HI_B(OSC_OUT_PER / 2), .LO_B(OSC_OUT_PER - OSC_OUT_PER / 2)
    ) u_osc_out (
        .clk_i(clk_i), .reset_i(reset_i), .run_i(!osc_out_dis_r && osc_run),
        .sel_i(1'b0), .clk_o(osc_out_pin_o)
    );

    // Buzzer tone; half period is a parameter so tests can shorten it
    cbpc_divider #(
        .HI_A(TONE_HALF), .LO_A(TONE_HALF), .HI_B(TONE_HALF), .LO_B(TONE_HALF)
    ) u_tone (
        .clk_i(clk_i), .reset_i(reset_i), .run_i(tone_run),
        .sel_i(1'b0), .clk_o(tone_lvl)
    );

    // Open drain: only ever pull low, the board pull-up gives high
    assign tone_pin_o = 1'b0;
    assign tone_pin_oe_o = !tone_lvl;

    // Comparator result also leaves on its own pin
    assign comparator_o = cmp_sync_r;

    // ***************************************************************
    // Battery sense sequencer
    // ***************************************************************
    cbpc_sense_e sense_r;
    cbpc_sense_e sense_nxt;
    logic [SW-1:0] sense_cnt_r;
    logic low_bat_r;
    logic short_r;
    logic strobe;

    assign strobe = clk_ctrl_r[B_BAT_STROBE];

    // Settle wait while the host holds the strobe
    always_comb begin
        sense_nxt = sense_r;
        case (sense_r)
            SENSE_IDLE: begin
                if (strobe) begin
                    sense_nxt = SENSE_SETTLE;
                end
            end
            SENSE_SETTLE: begin
                if (!strobe) begin
                    sense_nxt = SENSE_IDLE;
                end else if (sense_cnt_r == SW'(SENSE_WAIT - 1)) begin
                    sense_nxt = SENSE_READY;
                end
            end
            SENSE_READY: begin
                if (!strobe) begin
                    sense_nxt = SENSE_IDLE;
                end
            end
            default: begin
                sense_nxt = SENSE_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sense_r <= SENSE_IDLE;
        end else begin
            sense_r <= sense_nxt;
        end
    end

    // Settle counter, cleared outside the settle state
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sense_cnt_r <= '0;
        end else if (sense_r == SENSE_SETTLE) begin
            sense_cnt_r <= sense_cnt_r + 1'b1;
        end else begin
            sense_cnt_r <= '0;
        end
    end

    // Flag is caught as the strobe drops and held until the next drop
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            low_bat_r <= 1'b0;
            short_r <= 1'b0;
        end else if (sense_r != SENSE_IDLE && !strobe) begin
            low_bat_r <= bat_sync_r;
            short_r <= (sense_r == SENSE_SETTLE);
        end
    end

    // ***************************************************************
    // Status and read port
    // ***************************************************************
    logic saving;
    logic [7:0] status;
    logic [7:0] rdata_r;

    // Shows when the host has put every block into saving mode
    assign saving = (mode_r[3:1] == 3'h0) && (ohm_r == OHM_OFF)
                    && !cmp_en_r && !rct_en_r && !acbuf_en_r
                    && !conv_en_r && !ana_sw_r && !dig_sw_r
                    && osc_out_dis_r && xtal_dis_r && gnd_dis_r;

    always_comb begin
        status = 8'h00;
        status[S_LOW_BAT] = low_bat_r;
        status[S_CMP] = cmp_sync_r;
        status[S_SENSE_READY] = (sense_r == SENSE_READY);
        status[S_SHORT_SENSE] = short_r;
        status[S_TONE] = tone_run;
        status[S_SAVING] = saving;
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_r <= 8'h00;
        end else if (!bus_i.re) begin
            rdata_r <= 8'h00;
        end else if (bus_i.addr == REG_CLK_CTRL) begin
            rdata_r <= clk_ctrl_r;
        end else if (bus_i.addr == REG_FUNC) begin
            rdata_r <= {ohm_r, 2'h0, mode_r};
        end else if (bus_i.addr == REG_ANA_EN) begin
            rdata_r <= {1'b0, rct_en_r, 1'b0, acbuf_en_r, 3'h0, cmp_en_r};
        end else if (bus_i.addr == REG_CONV_GAIN) begin
            rdata_r <= {conv_en_r, 7'h00};
        end else if (bus_i.addr == REG_CONV_SETUP) begin
            rdata_r <= {ana_sw_r, dig_sw_r, 6'h00};
        end else if (bus_i.addr == REG_MISC_ONE) begin
            rdata_r <= {3'h0, osc_out_dis_r, xtal_dis_r, 3'h0};
        end else if (bus_i.addr == REG_MISC_TWO) begin
            rdata_r <= {6'h00, gnd_dis_r, 1'b0};
        end else if (bus_i.addr == REG_STATUS) begin
            rdata_r <= status;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata_o = rdata_r;

    // ***************************************************************
    // Analog control outputs
    // ***************************************************************
    // Straight from the registers, so no glitches reach the switches
    assign osc_disable_n_o = xtal_dis_r;
    assign osc_out_disable_o = osc_out_dis_r;
    assign ana_o = '{mode_r, ohm_r, cmp_en_r, rct_en_r, acbuf_en_r,
                     conv_en_r, ana_sw_r, dig_sw_r,
                     gnd_dis_r, strobe};

endmodule

`default_nettype wire

// *** hw/cbpc_pkg.sv ***
// Package for the clock, buzzer and power control block.
// Assumes a single 50 MHz system clock standing in for the crystal
// and a host that reaches 8-bit registers through a 4-bit index.
`default_nettype none

package cbpc_pkg;

    // ***************************************************************
    // Clock and timing
    // ***************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int XTAL_HZ = 4_000_000; // Crystal reference
    localparam int TB_FAST_HZ = 1_000_000; // 1.0000 MHz
    localparam int TB_SLOW_HZ = 125_000; // 125.0 kHz
    localparam int SMP_FAST_DIV = 24; // Crystal / 24, 166.67 kHz
    localparam int SMP_SLOW_DIV = 48; // Crystal / 48, 83.33 kHz
    localparam int OSC_OUT_HZ = 2_000_000; // 2.000 MHz
    localparam int TONE_HZ = 2_600; // About 2.6 kHz
    localparam int SENSE_TIME_NS = 100_000; // 0.1 ms settle

    // Full periods, tone half period and settle time in system clocks
    localparam int TB_FAST_PER = CLK_HZ / TB_FAST_HZ;
    localparam int TB_SLOW_PER = CLK_HZ / TB_SLOW_HZ;
    localparam int SMP_FAST_PER = CLK_HZ / (XTAL_HZ / SMP_FAST_DIV);
    localparam int SMP_SLOW_PER = CLK_HZ / (XTAL_HZ / SMP_SLOW_DIV);
    localparam int OSC_OUT_PER = CLK_HZ / OSC_OUT_HZ;
    localparam int TONE_PER = CLK_HZ / TONE_HZ;
    localparam int TONE_HALF_CYC = TONE_PER / 2;
    localparam int SENSE_CYC = (SENSE_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;

    // ***************************************************************
    // Register indices
    // ***************************************************************
    localparam logic [3:0] REG_CLK_CTRL = 4'h0;
    localparam logic [3:0] REG_FUNC = 4'h1;
    localparam logic [3:0] REG_ANA_EN = 4'h2;
    localparam logic [3:0] REG_CONV_GAIN = 4'h3;
    localparam logic [3:0] REG_CONV_SETUP = 4'h4;
    localparam logic [3:0] REG_MISC_ONE = 4'h5;
    localparam logic [3:0] REG_MISC_TWO = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;

    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int B_TB_SEL = 0;
    localparam int B_SMP_SEL = 1;
    localparam int B_TONE_FORCE = 2;
    localparam int B_CONT_TONE = 3;
    localparam int B_BAT_STROBE = 4;
    localparam int B_OHM_LO = 6; // Ohm source at [7:6]
    localparam int B_CMP_EN = 0;
    localparam int B_ACBUF_EN = 4;
    localparam int B_RCT_EN = 6;
    localparam int B_CONV_EN = 7;
    localparam int B_DIG_SW = 6;
    localparam int B_ANA_SW = 7;
    localparam int B_XTAL_DIS = 3;
    localparam int B_OSC_OUT_DIS = 4;
    localparam int B_GND_DIS = 1;
    localparam int S_LOW_BAT = 0;
    localparam int S_CMP = 1;
    localparam int S_SENSE_READY = 2;
    localparam int S_SHORT_SENSE = 3;
    localparam int S_TONE = 4;
    localparam int S_SAVING = 5;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] OHM_OFF = 2'h0;

    // ***************************************************************
    // Carriers
    // ***************************************************************
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } cbpc_bus_s;

    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] ohm_source_select;
        logic comparator_enable;
        logic rectifier_enable;
        logic ac_buffer_enable;
        logic converter_enable;
        logic analog_supply_switch_enable;
        logic digital_supply_switch_enable;
        logic ground_reg_disable;
        logic battery_sense_strobe;
    } cbpc_ana_s;

    typedef enum logic [1:0] {
        SENSE_IDLE,
        SENSE_SETTLE,
        SENSE_READY
    } cbpc_sense_e;

endpackage

`default_nettype wire

// *** hw/cbpc_divider.sv ***
// Gated square-wave divider with two selectable period pairs.
// Assumes run_i and sel_i come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module cbpc_divider #(
    parameter int HI_A = 25,
    parameter int LO_A = 25,
    parameter int HI_B = 200,
    parameter int LO_B = 200
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic run_i,
    input wire logic sel_i,
    output logic clk_o
);

    localparam int MAXA = (HI_A > LO_A) ? HI_A : LO_A;
    localparam int MAXB = (HI_B > LO_B) ? HI_B : LO_B;
    localparam int MAXC = (MAXA > MAXB) ? MAXA : MAXB;
    localparam int CW = $clog2(MAXC + 1);

    // ***************************************************************
    // Elaboration check
    // ***************************************************************
    if (HI_A < 1 || LO_A < 1 || HI_B < 1 || LO_B < 1) begin : g_chk
        $error("cbpc_divider: every phase needs one cycle or more");
    end

    logic [CW-1:0] cnt_r;
    logic out_r;
    logic sel_r;
    logic act_r;
    logic [CW-1:0] hi_end;
    logic [CW-1:0] lo_end;

    // Phase lengths follow the select latched at the period start
    assign hi_end = sel_r ? CW'(HI_B - 1) : CW'(HI_A - 1);
    assign lo_end = sel_r ? CW'(LO_B - 1) : CW'(LO_A - 1);

    // Whole periods only, so enable or select changes never glitch
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= '0;
            out_r <= 1'b0;
            sel_r <= 1'b0;
            act_r <= 1'b0;
        end else if (!act_r) begin
            cnt_r <= '0;
            out_r <= run_i;
            sel_r <= sel_i;
            act_r <= run_i;
        end else if (out_r) begin
            if (cnt_r == hi_end) begin
                cnt_r <= '0;
                out_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end else if (cnt_r == lo_end) begin
            cnt_r <= '0;
            out_r <= run_i;
            sel_r <= sel_i;
            act_r <= run_i;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign clk_o = out_r;

endmodule

`default_nettype wire

// *** sim/cbpc_top_checker.sv ***
// Checker on the control block ports: clocks, tone, pins, registers.
// Assumes TONE_HALF matches the bound instance.
`timescale 1ns/1ns
`default_nettype none
module cbpc_top_checker
    import cbpc_pkg::*;
#(
    parameter int TONE_HALF = 4
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire cbpc_pkg::cbpc_bus_s bus_i,
    input wire logic timebase_clock_o,
    input wire logic adc_sample_clock_o,
    input wire logic osc_out_pin_o,
    input wire logic tone_pin_o,
    input wire logic tone_pin_oe_o,
    input wire logic comparator_result_i,
    input wire logic comparator_o,
    input wire logic osc_disable_n_o,
    input wire logic osc_out_disable_o,
    input wire cbpc_pkg::cbpc_ana_s ana_o
);
    // ***
    // Helper state
    // ***
    logic [9:0] xoff_r;
    logic [9:0] ooff_r;
    logic [9:0] gcnt_r;
    logic [3:0] ohi_r;
    logic force_r;
    logic cont_r;
    logic gate_r;
    wire logic gate_nxt = force_r | (cont_r & comparator_o);
    // Stop counters saturate; ohi_r counts osc high cycles
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            xoff_r <= 10'h000;
            ooff_r <= 10'h000;
            ohi_r <= 4'h0;
        end else begin
            ohi_r <= osc_out_pin_o ? ohi_r + 4'h1 : 4'h0;
            xoff_r <= osc_disable_n_o ? xoff_r + {9'h000, ~&xoff_r} : 10'h000;
            ooff_r <= (osc_out_disable_o | osc_disable_n_o)
                      ? ooff_r + {9'h000, ~&ooff_r} : 10'h000;
        end
    end
    // Tone gate shadow and its age
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            force_r <= 1'b0;
            cont_r <= 1'b0;
            gate_r <= 1'b0;
            gcnt_r <= 10'h000;
        end else begin
            if (bus_i.we && bus_i.addr == REG_CLK_CTRL) begin
                force_r <= bus_i.wdata[B_TONE_FORCE];
                cont_r <= bus_i.wdata[B_CONT_TONE];
            end
            gate_r <= gate_nxt;
            gcnt_r <= (gate_nxt != gate_r) ? 10'h000
                      : gcnt_r + {9'h000, ~&gcnt_r};
        end
    end
    // ***
    // Assertions
    // ***
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    tb_period_a: assert property ($rose(timebase_clock_o) |-> ##24
        timebase_clock_o ##1 (!timebase_clock_o
        or (##174 timebase_clock_o ##1 !timebase_clock_o)))
        else $error("timebase high phase wrong");
    smp_period_a: assert property ($rose(adc_sample_clock_o) |-> ##149
        adc_sample_clock_o ##1 (!adc_sample_clock_o
        or (##149 adc_sample_clock_o ##1 !adc_sample_clock_o)))
        else $error("sample clock high phase wrong");
    xtal_off_a: assert property ((xoff_r > 10'h262) |->
        !timebase_clock_o && !adc_sample_clock_o)
        else $error("divided clock runs with oscillator off");
    osc_wave_a: assert property ($fell(osc_out_pin_o) |-> ohi_r == 4'hC)
        else $error("oscillator output phase wrong");
    osc_off_a: assert property ((ooff_r > 10'h01E) |-> !osc_out_pin_o)
        else $error("oscillator output not held low");
    tone_quiet_a: assert property ((!gate_r && gcnt_r > 2 * TONE_HALF + 2)
        |-> tone_pin_oe_o)
        else $error("tone runs with gate closed");
    tone_run_a: assert property ((gate_r && gcnt_r > 4 * TONE_HALF) |->
        tone_pin_oe_o != $past(tone_pin_oe_o, TONE_HALF))
        else $error("tone not a square wave");
    drain_a: assert property (tone_pin_o == 1'b0)
        else $error("tone pin driven high");
    cmp_pin_a: assert property (!$past(reset_i, 2) |->
        comparator_o == $past(comparator_result_i, 2))
        else $error("comparator pin lags wrongly");
    supply_sw_a: assert property (bus_i.we && bus_i.addr == REG_CONV_SETUP
        |=> ana_o.analog_supply_switch_enable == $past(bus_i.wdata[B_ANA_SW])
        && ana_o.digital_supply_switch_enable == $past(bus_i.wdata[B_DIG_SW]))
        else $error("supply switch enables wrong");
endmodule
`default_nettype wire

// *** sim/cbpc_host.sv ***
// Host model: owns the register port of the control block.
// Assumes every task is called just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module cbpc_host
    import cbpc_pkg::*;
(
    input wire logic clk_i,
    output cbpc_pkg::cbpc_bus_s bus_o
);
    // ***
    // Bus cycles
    // ***
    initial bus_o = 14'h0000;
    // Back-to-back calls drive once per edge
    task automatic cyc(input logic [3:0] a, input logic [7:0] d,
                       input logic w, input logic r);
        bus_o <= '{a, d, w, r};
        @(posedge clk_i);
    endtask
    task automatic idle(input int n);
        repeat (n) cyc(4'h0, 8'h00, 1'b0, 1'b0);
    endtask
    // Strobe up, hold, drop, let the flag land
    task automatic sense(input int hold);
        cyc(REG_CLK_CTRL, 8'h10, 1'b1, 1'b0);
        idle(hold);
        cyc(REG_CLK_CTRL, 8'h00, 1'b1, 1'b0);
        idle(2);
    endtask
    // All consumers off and the three disables set
    task automatic saving();
        cyc(REG_FUNC, 8'h00, 1'b1, 1'b0);
        cyc(REG_ANA_EN, 8'h00, 1'b1, 1'b0);
        cyc(REG_CONV_GAIN, 8'h00, 1'b1, 1'b0);
        cyc(REG_CONV_SETUP, 8'h00, 1'b1, 1'b0);
        cyc(REG_MISC_ONE, 8'h18, 1'b1, 1'b0);
        cyc(REG_MISC_TWO, 8'h02, 1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Top testbench for the clock, buzzer and power control block.
// Assumes host model and checker compile first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import cbpc_pkg::*;
    localparam int TH = 4;
    localparam int SW = 8;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cmp = 1'b0;
    logic bat = 1'b0;
    logic rd_q = 1'b0;
    cbpc_bus_s bus;
    logic [7:0] rdata;
    logic [15:0] exp_q[$];
    int failures = 0;
    int samples_checked = 0;
    logic [7:0] m [7] = '{8'h1F, 8'hCF, 8'h51, 8'h80, 8'hC0, 8'h18, 8'h02};
    cbpc_host u_cbpc_host (.clk_i(clk_i), .bus_o(bus));
    cbpc_top #(.TONE_HALF(TH), .SENSE_WAIT(SW)) u_cbpc_top (
        .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata),
        .comparator_result_i(cmp), .battery_below_i(bat),
        .timebase_clock_o(), .adc_sample_clock_o(), .osc_out_pin_o(),
        .tone_pin_o(), .tone_pin_oe_o(), .comparator_o(),
        .osc_disable_n_o(), .osc_out_disable_o(), .ana_o());
    initial forever #10 clk_i = ~clk_i;
    // ***
    // Tasks
    // ***
    task automatic chk(input logic [7:0] e, input logic [7:0] g,
                       input logic [7:0] mk);
        samples_checked++;
        if ((g & mk) !== e) begin
            failures++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g & mk);
        end
    endtask
    // Note the expected value, then read
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input logic [7:0] mk);
        exp_q.push_back({mk, e});
        u_cbpc_host.cyc(a, 8'h00, 1'b0, 1'b1);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_cbpc_host.cyc(a, d, 1'b1, 1'b0);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        rd_q <= bus.re;
        if (rd_q && exp_q.size() > 0) begin
            chk(exp_q[0][7:0], rdata, exp_q[0][15:8]);
            void'(exp_q.pop_front());
        end
    end
    // ***
    // Main sequence
    // ***
    initial begin
        int b;
        logic [7:0] d;
        b = $urandom(32'h3E0A7A67);
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 16; i++)
            rd(i[3:0], 8'h00, 8'hFF);
        for (int i = 0; i < 7; i++) begin
            d = $urandom;
            wr(i[3:0], d);
            rd(i[3:0], d & m[i], 8'hFF);
        end
        wr(4'hA, 8'hFF);
        rd(4'hA, 8'h00, 8'hFF);
        wr(REG_MISC_ONE, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(REG_CLK_CTRL, s[7:0]);
            u_cbpc_host.idle(1300);
        end
        wr(REG_MISC_ONE, 8'h10);
        u_cbpc_host.idle(40);
        wr(REG_MISC_ONE, 8'h08);
        u_cbpc_host.idle(700);
        wr(REG_MISC_ONE, 8'h00);
        for (int k = 0; k < 8; k++) begin
            cmp <= k[2];
            wr(REG_CLK_CTRL, {4'h0, k[1:0], 2'h0});
            u_cbpc_host.idle(6 * TH);
            rd(REG_STATUS, {3'h0, k[0] | (k[1] & k[2]), 2'h0, k[2], 1'b0},
               8'h12);
        end
        u_cbpc_host.sense(SW - 2);
        rd(REG_STATUS, 8'h08, 8'h08);
        for (int k = 0; k < 2; k++) begin
            b = $urandom;
            bat <= b[0] ^ k[0];
            u_cbpc_host.sense(SW + 2);
            rd(REG_STATUS, {7'h00, b[0] ^ k[0]}, 8'h09);
        end
        u_cbpc_host.saving();
        rd(REG_STATUS, 8'h20, 8'h20);
        rd(REG_MISC_TWO, 8'h02, 8'hFF);
        u_cbpc_host.idle(3);
        if (exp_q.size() != 0)
            failures++;
        tally_and_finish();
    end
endmodule
bind cbpc_top cbpc_top_checker #(.TONE_HALF(TONE_HALF)) u_cbpc_top_checker (
    .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i),
    .timebase_clock_o(timebase_clock_o),
    .adc_sample_clock_o(adc_sample_clock_o), .osc_out_pin_o(osc_out_pin_o),
    .tone_pin_o(tone_pin_o), .tone_pin_oe_o(tone_pin_oe_o),
    .comparator_result_i(comparator_result_i), .comparator_o(comparator_o),
    .osc_disable_n_o(osc_disable_n_o), .osc_out_disable_o(osc_out_disable_o),
    .ana_o(ana_o));
`default_nettype wire
